// ===== swx_xcvr_ctrl.sv
/*
  Transceiver control: pin synchronisers, transmit load path and FIFO,
  serial transmitter with parity, self-test loopback, two receivers with
  half-word readout, repeater mode and master clear.
  Assumes host pins are asynchronous to mclk; mclk is 100 MHz.
*/
`timescale 1ns/1ns
module swx_xcvr_ctrl
    import swx_pkg::*;
(
    input wire logic               mclk,
    input wire logic               rst,
    input wire logic               master_clear,
    input wire logic               load_first_half,
    input wire logic               load_second_half,
    input wire logic               rx_one_read_strobe,
    input wire logic               rx_two_read_strobe,
    input wire logic               half_select,
    input wire logic               tx_launch_enable,
    input wire logic               tx_parity_select,
    input wire logic               loopback_test_select,
    input wire logic               slope_select,
    input wire logic               tx_rate_select,
    input wire logic               rx_rate_select,
    input wire logic               repeater_mode,
    input wire logic               line_in_one_pos,
    input wire logic               line_in_one_neg,
    input wire logic               line_in_two_pos,
    input wire logic               line_in_two_neg,
    input wire logic [HALF_W-1:0]  data_in,
    output logic [HALF_W-1:0]      data_out,
    output logic                   data_oe,
    output logic                   line_out_pos,
    output logic                   line_out_neg,
    output logic                   slope_slow,
    output logic                   tx_ready,
    output logic                   rx_one_word_ready,
    output logic                   rx_two_word_ready
);
    function automatic logic [WORD_W-1:0] pack_word(input logic [HALF_W-1:0] h1, input logic [HALF_W-1:0] h2);
        logic [WORD_W-1:0] w;
        w = '0;
        for (int k = 0; k < 8; k++)
            w[k] = h1[7-k];
        for (int k = 0; k < 5; k++)
            w[8+k] = h1[11+k];
        w[28:13] = h2;
        w[29]    = h1[9];
        w[30]    = h1[10];
        return w;
    endfunction

    // Receive half: bit 8 of the lower half reports the parity check
    function automatic logic [HALF_W-1:0] unpack_half(input logic [ARINC_W-1:0] a, input logic upper);
        logic [HALF_W-1:0] h;
        h = '0;
        for (int k = 0; k < 8; k++)
            h[7-k] = a[k];
        h[15:11] = a[12:8];
        h[10]    = a[30];
        h[9]     = a[29];
        h[8]     = ~(^a);
        if (upper)
            h = a[28:13];
        return h;
    endfunction

    // Pin synchroniser; a change counts once stages two and three agree
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    logic              mc_f, pl1_f, pl2_f, sel_f, tx_launch_enable_f, par_f, loop_f, slope_f;
    logic              txslow_f, rxslow_f, rep_f;
    logic [1:0]        en_f, lpos_f, lneg_f;
    logic [HALF_W-1:0] din_f;

    // Control settings are plain pins, so master clear cannot disturb them
    assign {mc_f, pl1_f, pl2_f, en_f[0], en_f[1], sel_f, tx_launch_enable_f, par_f, loop_f, slope_f,
            txslow_f, rxslow_f, rep_f, lpos_f[0], lneg_f[0], lpos_f[1], lneg_f[1], din_f} = filt_q;

    always_comb
    begin
        filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            filt_q <= '0;
        end
        else
        begin
            s1_q   <= {master_clear, load_first_half, load_second_half, rx_one_read_strobe,
                       rx_two_read_strobe, half_select, tx_launch_enable, tx_parity_select,
                       loopback_test_select, slope_select, tx_rate_select, rx_rate_select,
                       repeater_mode, line_in_one_pos, line_in_one_neg, line_in_two_pos,
                       line_in_two_neg, data_in};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    // Tick divider, strobe edges, load path and readout
    logic [6:0]          tick_cnt_q, tick_cnt_d;
    logic                tick_q, tick_d;
    logic [3:0]          strb_q;
    logic                pl1_rise, pl2_rise, rd_any, first_ev, second_ev;
    logic [1:0]          rd_rise;
    logic [HALF_W-1:0]   rd_half, ev_data, h1_q, h1_d, dout_d;
    logic                wr_valid_q, wr_valid_d, oe_d;
    logic [WORD_W-1:0]   wr_data_q, wr_data_d;
    logic [1:0]          rdy_q, rdy_d, lo_rd_q, lo_rd_d, hi_rd_q, hi_rd_d, rx_done;
    logic [ARINC_W-1:0]  rx_word [NUM_RX];
    logic [NUM_RX-1:0]   rx_hi, rx_lo;

    swx_stream_if #(.WIDTH(WORD_W)) wr_if ();
    swx_stream_if #(.WIDTH(WORD_W)) rd_if ();

    assign pl1_rise  = pl1_f & ~strb_q[3];
    assign pl2_rise  = pl2_f & ~strb_q[2];
    assign rd_rise   = en_f & ~strb_q[1:0];
    assign rd_any    = |rd_rise;
    assign rd_half   = unpack_half(rx_word[en_f[0] ? 0 : 1], sel_f);
    assign first_ev  = pl1_rise | (rep_f & rd_any & ~sel_f);
    assign second_ev = pl2_rise | (rep_f & rd_any & sel_f);
    assign ev_data   = (rep_f & rd_any) ? rd_half : din_f;
    assign wr_if.valid = wr_valid_q;
    assign wr_if.data  = wr_data_q;

    always_comb
    begin
        tick_cnt_d = (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 7'h01;
        tick_d     = (tick_cnt_q == TICK_LAST);
        h1_d       = first_ev ? ev_data : h1_q;
        wr_valid_d = second_ev & wr_if.ready & ~mc_f;
        wr_data_d  = second_ev ? pack_word(h1_q, ev_data) : wr_data_q;
        oe_d       = |en_f;
        dout_d     = oe_d ? rd_half : data_out;
        for (int i = 0; i < NUM_RX; i++)
        begin
            lo_rd_d[i] = rdy_q[i] & (lo_rd_q[i] | (rd_rise[i] & ~sel_f));
            hi_rd_d[i] = rdy_q[i] & (hi_rd_q[i] | (rd_rise[i] & sel_f));
            rdy_d[i]   = rx_done[i] | (rdy_q[i] & ~(lo_rd_d[i] & hi_rd_d[i]));
            if (rx_done[i] || mc_f)
            begin
                lo_rd_d[i] = 1'b0;
                hi_rd_d[i] = 1'b0;
            end
        end
        if (mc_f)
        begin
            rdy_d = '0;
            h1_d  = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
            strb_q     <= '0;
            h1_q       <= '0;
            wr_valid_q <= 1'b0;
            wr_data_q  <= '0;
            data_oe    <= 1'b0;
            data_out   <= '0;
            rdy_q      <= '0;
            lo_rd_q    <= '0;
            hi_rd_q    <= '0;
            slope_slow <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
            strb_q     <= {pl1_f, pl2_f, en_f};
            h1_q       <= h1_d;
            wr_valid_q <= wr_valid_d;
            wr_data_q  <= wr_data_d;
            data_oe    <= oe_d;
            data_out   <= dout_d;
            rdy_q      <= rdy_d;
            lo_rd_q    <= lo_rd_d;
            hi_rd_q    <= hi_rd_d;
            slope_slow <= slope_f;
        end
    end

    assign rx_one_word_ready = rdy_q[0];
    assign rx_two_word_ready = rdy_q[1];

    swx_fifo #(.WIDTH(WORD_W), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
        .mclk (mclk),
        .rst  (rst),
        .clr  (mc_f),
        .wr   (wr_if),
        .rd   (rd_if)
    );

    // Transmitter: mark half, null half per bit, then the word gap
    swx_tx_state_t     tx_st_q, tx_st_d;
    logic [ARINC_W-1:0] shift_q, shift_d;
    logic [4:0]        bit_q, bit_d;
    logic [8:0]        time_q, time_d, half_t;
    logic              pos_d, neg_d, pop, parity, ready_d;

    assign pop         = (tx_st_q == TX_IDLE) & tx_launch_enable_f & rd_if.valid & ~mc_f;
    assign rd_if.ready = pop;
    assign half_t      = txslow_f ? TX_HALF_SLOW : TX_HALF_FAST;
    assign parity      = par_f ? (^rd_if.data) : ~(^rd_if.data);

    always_comb
    begin
        tx_st_d = tx_st_q;
        shift_d = shift_q;
        bit_d   = bit_q;
        time_d  = time_q;
        pos_d   = line_out_pos;
        neg_d   = line_out_neg;
        unique case (tx_st_q)
            TX_IDLE:
                if (pop)
                begin
                    shift_d = {parity, rd_if.data};
                    bit_d   = '0;
                    time_d  = half_t;
                    pos_d   = rd_if.data[0];
                    neg_d   = ~rd_if.data[0];
                    tx_st_d = TX_MARK;
                end
            TX_MARK:
                if (tick_q)
                begin
                    time_d = time_q - 9'h001;
                    if (time_q == 9'h001)
                    begin
                        time_d  = half_t;
                        pos_d   = 1'b0;
                        neg_d   = 1'b0;
                        tx_st_d = TX_SPACE;
                    end
                end
            TX_SPACE:
                if (tick_q)
                begin
                    time_d = time_q - 9'h001;
                    if (time_q == 9'h001 && bit_q == LAST_BIT)
                    begin
                        time_d  = txslow_f ? TX_GAP_SLOW : TX_GAP_FAST;
                        tx_st_d = TX_GAP;
                    end
                    else if (time_q == 9'h001)
                    begin
                        shift_d = shift_q >> 1;
                        bit_d   = bit_q + 5'h01;
                        time_d  = half_t;
                        pos_d   = shift_q[1];
                        neg_d   = ~shift_q[1];
                        tx_st_d = TX_MARK;
                    end
                end
            TX_GAP:
                if (tick_q)
                begin
                    time_d = time_q - 9'h001;
                    if (time_q == 9'h001)
                        tx_st_d = TX_IDLE;
                end
        endcase
        if (mc_f)
        begin
            tx_st_d = TX_IDLE;
            pos_d   = 1'b0;
            neg_d   = 1'b0;
        end
        ready_d = (tx_st_d == TX_IDLE) & ~rd_if.valid & ~wr_valid_q & ~pop;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tx_st_q      <= TX_IDLE;
            shift_q      <= '0;
            bit_q        <= '0;
            time_q       <= '0;
            line_out_pos <= 1'b0;
            line_out_neg <= 1'b0;
            tx_ready     <= 1'b1;
        end
        else
        begin
            tx_st_q      <= tx_st_d;
            shift_q      <= shift_d;
            bit_q        <= bit_d;
            time_q       <= time_d;
            line_out_pos <= pos_d;
            line_out_neg <= neg_d;
            tx_ready     <= ready_d;
        end
    end

    // Self test: loop the driver levels in, complemented for receiver two
    assign rx_hi[0] = loop_f ? lpos_f[0] : line_out_pos;
    assign rx_lo[0] = loop_f ? lneg_f[0] : line_out_neg;
    assign rx_hi[1] = loop_f ? lpos_f[1] : line_out_neg;
    assign rx_lo[1] = loop_f ? lneg_f[1] : line_out_pos;

    for (genvar g = 0; g < NUM_RX; g++)
    begin : g_rx
        swx_rx u_rx (
            .mclk   (mclk),
            .rst    (rst),
            .clr    (mc_f),
            .tick   (tick_q),
            .slow   (rxslow_f),
            .hi     (rx_hi[g]),
            .lo     (rx_lo[g]),
            .word_q (rx_word[g]),
            .done_q (rx_done[g])
        );
    end

    sequence s_pop_start;
        pop ##1 (tx_st_q == TX_MARK);
    endsequence

    a_parity_total: assert property (@(posedge mclk) disable iff (rst)
        s_pop_start |-> ((^shift_q) == !$past(par_f)))
        else $error("transmitted parity wrong");
    a_loop_route: assert property (@(posedge mclk) disable iff (rst)
        !loop_f |-> (rx_hi[0] == line_out_pos && rx_lo[0] == line_out_neg &&
                     rx_hi[1] == line_out_neg && rx_lo[1] == line_out_pos))
        else $error("self test routing wrong");
    a_line_driven_mark: assert property (@(posedge mclk) disable iff (rst)
        (tx_st_q == TX_MARK && $past(tx_st_q) == TX_MARK) |-> (line_out_pos != line_out_neg))
        else $error("line not driven during bit");
    a_rdy_both_halves: assert property (@(posedge mclk) disable iff (rst)
        ($fell(rdy_q[0]) && !$past(mc_f)) |-> $past(lo_rd_d[0] && hi_rd_d[0]))
        else $error("ready cleared before both halves read");
    a_slope_follow: assert property (@(posedge mclk) disable iff (rst)
        $rose(slope_f) |=> slope_slow ##1 slope_slow)
        else $error("slope select not applied");
    a_repeat_push: assert property (@(posedge mclk) disable iff (rst)
        (rep_f && rd_any && sel_f && wr_if.ready && !mc_f) |=> wr_valid_q)
        else $error("repeater word not loaded");
    a_clear_quiet: assert property (@(posedge mclk) disable iff (rst)
        mc_f |=> (tx_st_q == TX_IDLE && !line_out_pos && !line_out_neg && rdy_q == '0) ##1 !rd_if.valid)
        else $error("master clear incomplete");
    a_ready_idle: assert property (@(posedge mclk) disable iff (rst)
        tx_ready |-> (tx_st_q == TX_IDLE && !rd_if.valid))
        else $error("ready while sending");
endmodule

// ===== swx_pkg.sv
/*
  Shared constants for the serial word transceiver control block.
  Assumes a 100 MHz mclk and a 1 us bit-timing tick derived from it.
*/
package swx_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
    localparam logic [8:0] TX_HALF_FAST = 9'h005;
    localparam logic [8:0] TX_HALF_SLOW = 9'h028;
    localparam logic [8:0] TX_GAP_FAST  = 9'h028;
    localparam logic [8:0] TX_GAP_SLOW  = 9'h140;
    localparam logic [8:0] RX_GAP_FAST  = 9'h014;
    localparam logic [8:0] RX_GAP_SLOW  = 9'h0A0;
    localparam logic [4:0] LAST_BIT     = 5'h1F;
    localparam int HALF_W        = 16;
    localparam int WORD_W        = 31;
    localparam int ARINC_W       = 32;
    localparam int NUM_RX        = 2;
    localparam int TX_FIFO_DEPTH = 8;
    localparam int SYNC_W        = 33;
    typedef enum logic [1:0] {TX_IDLE, TX_MARK, TX_SPACE, TX_GAP} swx_tx_state_t;
endpackage

// ===== swx_stream_if.sv
/*
  Valid/ready word stream between the controller and its FIFO.
  Assumes both ends share mclk.
*/
`timescale 1ns/1ns
interface swx_stream_if #(parameter int WIDTH = 31);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== swx_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a clear input.
  Assumes single clock mclk and synchronous active-high reset.
*/
`timescale 1ns/1ns
module swx_fifo #(
    parameter int WIDTH = 31,
    parameter int DEPTH = 4
) (
    input wire logic  mclk,
    input wire logic  rst,
    input wire logic  clr,
    swx_stream_if.snk wr,
    swx_stream_if.src rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             push, pop;

    assign wr.ready = (cnt_q != CW'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data  = mem[rp_q];
    assign push     = wr.valid & wr.ready;
    assign pop      = rd.valid & rd.ready;

    always_comb
    begin
        wp_d  = push ? ((wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1) : wp_q;
        rp_d  = pop ? ((rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q + CW'(push) - CW'(pop);
        if (clr)
        begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage carries no reset; the count and read pointer define what is valid
    always_ff @(posedge mclk)
    begin
        if (push && !clr)
            mem[wp_q] <= wr.data;
    end

    a_fifo_full_refuse: assert property (@(posedge mclk) disable iff (rst)
        (cnt_q == CW'(DEPTH) && !pop && !clr) |=> (cnt_q == CW'(DEPTH) && $stable(wp_q)))
        else $error("full FIFO accepted a word");
endmodule

// ===== swx_rx.sv
/*
  Receiver word assembler: takes digital one/zero levels, collects 32 bits.
  Assumes levels already synchronised and a 1 us tick enable.
*/
`timescale 1ns/1ns
module swx_rx
    import swx_pkg::*;
(
    input wire logic            mclk,
    input wire logic            rst,
    input wire logic            clr,
    input wire logic            tick,
    input wire logic            slow,
    input wire logic            hi,
    input wire logic            lo,
    output logic [ARINC_W-1:0]  word_q,
    output logic                done_q
);
    logic               act_q, act_d, done_d, active;
    logic [ARINC_W-1:0] shift_q, shift_d, word_d;
    logic [4:0]         cnt_q, cnt_d;
    logic [8:0]         null_q, null_d, gap;

    always_comb
    begin
        act_d   = act_q;
        shift_d = shift_q;
        word_d  = word_q;
        cnt_d   = cnt_q;
        null_d  = null_q;
        done_d  = 1'b0;
        active  = hi | lo;
        gap     = slow ? RX_GAP_SLOW : RX_GAP_FAST;
        if (clr)
        begin
            act_d  = 1'b0;
            cnt_d  = '0;
            null_d = '0;
            word_d = '0;
        end
        else if (tick)
        begin
            act_d = active;
            if (active)
            begin
                null_d = '0;
                if (!act_q)
                begin
                    shift_d = {hi, shift_q[ARINC_W-1:1]};
                    cnt_d   = cnt_q + 5'h01;
                    if (cnt_q == LAST_BIT)
                    begin
                        word_d = shift_d;
                        done_d = 1'b1;
                    end
                end
            end
            else if (null_q != gap)
                null_d = null_q + 9'h001;
            else
                cnt_d = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            act_q   <= 1'b0;
            shift_q <= '0;
            word_q  <= '0;
            cnt_q   <= '0;
            null_q  <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            act_q   <= act_d;
            shift_q <= shift_d;
            word_q  <= word_d;
            cnt_q   <= cnt_d;
            null_q  <= null_d;
            done_q  <= done_d;
        end
    end

    a_rx_word_count: assert property (@(posedge mclk) disable iff (rst)
        done_q |-> ($past(cnt_q) == LAST_BIT && cnt_q == '0))
        else $error("word completed at wrong bit count");
endmodule

// ===== swx_host_model.sv
/*
  Host controller model for the 16-bit parallel side: word loads and half-word reads.
  Assumes mclk from the bench; drives only just after falling edges.
*/
`timescale 1ns/1ns
module swx_host_model (
    input wire logic         mclk,
    input wire logic [15:0]  data_out,
    input wire logic         data_oe,
    output logic             load_first_half,
    output logic             load_second_half,
    output logic             rx_one_read_strobe,
    output logic             rx_two_read_strobe,
    output logic             half_select,
    output logic [15:0]      data_in
);
    initial
    begin
        load_first_half = 0;
        load_second_half = 0;
        rx_one_read_strobe = 0;
        rx_two_read_strobe = 0;
        half_select = 0;
        data_in = 16'h0000;
    end

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Data held well past the strobe, the pins pass a synchroniser first
    task automatic load_word(input logic [15:0] a, input logic [15:0] b);
        step(1);
        data_in = a;
        load_first_half = 1;
        step(8);
        load_first_half = 0;
        step(6);
        data_in = b;
        load_second_half = 1;
        step(8);
        load_second_half = 0;
        step(6);
        data_in = ~b;
    endtask

    task automatic read_half(input logic two, input logic sel, output logic [15:0] d, output logic oe);
        step(1);
        half_select = sel;
        step(1);
        if (two)
            rx_two_read_strobe = 1;
        else
            rx_one_read_strobe = 1;
        step(10);
        d = data_out;
        oe = data_oe;
        rx_one_read_strobe = 0;
        rx_two_read_strobe = 0;
        step(6);
    endtask
endmodule

// ===== swx_xcvr_ctrl_test.sv
/*
  Self-checking bench: self-test loopback words, parity, readout, repeater, master clear.
  Assumes the host model above and a 100 MHz mclk.
*/
`timescale 1ns/1ns
module swx_xcvr_ctrl_test;
    import swx_pkg::*;
    logic mclk = 0, rst = 1, master_clear = 0, tx_launch_enable = 0, tx_parity_select = 0;
    logic loopback_test_select = 0, slope_select = 0, repeater_mode = 0, act_q = 0;
    logic [3:0]   line_in = 4'h0;
    logic [32:1]  cap = '0;
    logic [32:1]  exp_q[$];
    wire logic    lf, ls, r1, r2, sel, oe, lp, ln, slope_slow, tx_ready, rdy1, rdy2;
    wire logic [15:0] din, dout;
    int failures = 0, tests_run = 0, cycles = 0, ncap = 0;

    swx_xcvr_ctrl u_dut (.mclk(mclk), .rst(rst), .master_clear(master_clear), .load_first_half(lf),
        .load_second_half(ls), .rx_one_read_strobe(r1), .rx_two_read_strobe(r2), .half_select(sel),
        .tx_launch_enable(tx_launch_enable), .tx_parity_select(tx_parity_select),
        .loopback_test_select(loopback_test_select), .slope_select(slope_select), .tx_rate_select(1'b0),
        .rx_rate_select(1'b0), .repeater_mode(repeater_mode), .line_in_one_pos(line_in[0]),
        .line_in_one_neg(line_in[1]), .line_in_two_pos(line_in[2]), .line_in_two_neg(line_in[3]),
        .data_in(din), .data_out(dout), .data_oe(oe), .line_out_pos(lp), .line_out_neg(ln),
        .slope_slow(slope_slow), .tx_ready(tx_ready), .rx_one_word_ready(rdy1), .rx_two_word_ready(rdy2));
    swx_host_model u_host (.mclk(mclk), .data_out(dout), .data_oe(oe), .load_first_half(lf),
        .load_second_half(ls), .rx_one_read_strobe(r1), .rx_two_read_strobe(r2), .half_select(sel),
        .data_in(din));

    always #5 mclk = ~mclk;
    // Line noise that self test must shut out
    always @(negedge mclk) line_in <= 4'($urandom);
    always @(posedge mclk)
    begin
        act_q <= lp | ln;
        if ((lp | ln) && !act_q)
        begin
            cap <= {lp, cap[32:2]};
            ncap <= ncap + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("%0d compares, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    function automatic logic [32:1] to_word(input logic [15:0] a, input logic [15:0] b, input logic even);
        logic [32:1] w;
        for (int i = 1; i <= 8; i++) w[i] = a[8-i];
        for (int i = 9; i <= 13; i++) w[i] = a[i+2];
        for (int i = 14; i <= 29; i++) w[i] = b[i-14];
        w[30] = a[9];
        w[31] = a[10];
        w[32] = ^w[31:1] ^ ~even;
        return w;
    endfunction

    task automatic round(input logic even);
        logic [15:0] a, b, d;
        logic        o;
        int          n0;
        a = 16'($urandom);
        b = 16'($urandom);
        n0 = ncap;
        exp_q.push_back(to_word(a, b, even));
        tx_parity_select = even;
        u_host.load_word(a, b);
        check(tx_ready, 0);
        tx_launch_enable = 1;
        for (int i = 0; i < 40000 && tx_ready !== 1'b1; i++) cyc(1);
        check(tx_ready, 1);
        check(ncap - n0, 32);
        check(cap, exp_q.pop_front());
        cyc(10);
        check({rdy1, rdy2}, 2'b11);
        tx_launch_enable = 0;
        u_host.read_half(0, 1, d, o);
        check({o, d}, {1'b1, b});
        check(rdy1, 1);
        u_host.read_half(0, 0, d, o);
        check(d, {a[15:9], even, a[7:0]});
        repeater_mode = even;
        u_host.read_half(1, 0, d, o);
        check(d, {~a[15:9], even, ~a[7:0]});
        u_host.read_half(1, 1, d, o);
        check(d, 16'(~b));
        cyc(8);
        check({rdy1, rdy2}, 0);
        check(tx_ready, !even);
        $display("round with parity select %0d done", even);
    endtask

    initial
    begin
        void'($urandom(32'hA1566D48));
        repeat (5) @(negedge mclk);
        rst = 0;
        cyc(8);
        check({tx_ready, rdy1, rdy2, slope_slow}, 4'h8);
        for (int i = 0; i < 9; i++) u_host.load_word(16'($urandom), 16'($urandom));
        check(tx_ready, 0);
        master_clear = 1;
        cyc(10);
        check(tx_ready, 1);
        master_clear = 0;
        cyc(8);
        $display("fill and clear done");
        round(0);
        round(1);
        slope_select = 1;
        master_clear = 1;
        cyc(10);
        check({tx_ready, rdy1, rdy2}, 3'h4);
        check(slope_slow, 1);
        master_clear = 0;
        $display("final clear done");
        stop_test();
    end
endmodule
